// [bench/tb_vpwtx_link.sv]
`timescale 1ns/1ps
module tb_vpwtx_link;
	import vpwtx_pkg::*;
	logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, busRxIn, eodSeen, crcOk;
	logic busError, arbLost, byteSeen, digitalTxOutput, txDriveEn;
	logic digitalRxInput, fastMode;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int errors = 0, cmp_count = 0;
	always #2.5 sys_clk = ~sys_clk;
	vpwtx_link #(.BIT_CYC_NORM(8), .BIT_CYC_4X(2)) dut (.sys_clk(sys_clk),
		.arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busRxIn(busRxIn), .eodSeen(eodSeen),
		.crcOk(crcOk), .busError(busError), .arbLost(arbLost),
		.byteSeen(byteSeen), .digitalTxOutput(digitalTxOutput),
		.txDriveEn(txDriveEn), .digitalRxInput(digitalRxInput),
		.fastMode(fastMode));
	vpwtx_bus_model bus (.sys_clk(sys_clk), .digitalTxOutput(digitalTxOutput),
		.txDriveEn(txDriveEn), .busRxIn(busRxIn), .eodSeen(eodSeen),
		.crcOk(crcOk), .busError(busError), .arbLost(arbLost),
		.byteSeen(byteSeen));
	task test_done;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge sys_clk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
		if (n == 50) begin
			errors++;
			test_done;
		end
	endtask : apb
	task waitDrv(input logic lvl);
		int n;
		for (n = 0; n < 400; n++) begin
			@(negedge sys_clk);
			if (txDriveEn === lvl) break;
		end
		if (n == 400) begin
			errors++;
			test_done;
		end
	endtask : waitDrv
	task tLoop;
		apb(1, CTRL_OFS, 32'h1);
		bus.jam = 1'b1;
		@(posedge sys_clk);
		chk(digitalRxInput, 1'b0);
		apb(1, CTRL_OFS, 32'h0);
		@(posedge sys_clk);
		chk(digitalRxInput, 1'b1);
		bus.jam = 1'b0;
	endtask : tLoop
	task tFast;
		apb(1, CTRL_OFS, 32'h42);
		bus.pulseEod(1'b1);
		repeat (40) @(posedge sys_clk);
		chk({fastMode, txDriveEn}, 2'b10);
		apb(1, CTRL_OFS, 32'h0);
	endtask : tFast
	task tLate;
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= CTRL_OFS;
		pwdata <= 32'h40;
		@(posedge sys_clk);
		penable <= 1'b1;
		bus.eodSeen <= 1'b1;
		@(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		bus.eodSeen <= 1'b0;
		@(posedge sys_clk);
		apb(0, CTRL_OFS, 32'h0);
		chk(rd[RSPS_BIT], 1'b0);
		repeat (20) @(posedge sys_clk);
		chk(txDriveEn, 1'b0);
	endtask : tLate
	task rsp(input logic [2:0] code, input logic fmt, input logic nb);
		logic [7:0] data;
		logic multi;
		data = 8'hA5;
		multi = !code[2] && code[1];
		apb(1, CTRL_OFS, {25'h0, code, 1'b0, fmt, 2'b00});
		apb(1, DATA_OFS, {24'h0, data});
		apb(0, CTRL_OFS, 32'h0);
		chk(rd[6:4], code);
		bus.pulseEod(1'b1);
		waitDrv(1'b1);
		@(posedge sys_clk);
		if (multi) apb(1, CTRL_OFS, {25'h0, code, 1'b1, fmt, 2'b00});
		else repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(digitalTxOutput, nb);
		for (int i = 7; i >= 0; i--) begin
			repeat (8) @(negedge sys_clk);
			chk(digitalTxOutput, data[i]);
		end
		waitDrv(1'b0);
		@(posedge sys_clk);
		bus.pulseEod(1'b1);
		apb(0, CTRL_OFS, 32'h0);
		chk(rd[6:3], 4'h0);
	endtask : rsp
	task tArb;
		logic [7:0] d;
		d = 8'hA5;
		apb(1, CTRL_OFS, 32'h40);
		apb(1, DATA_OFS, {24'h0, d});
		bus.pulseEod(1'b1);
		waitDrv(1'b1);
		repeat (12) @(posedge sys_clk);
		bus.strobe(3'b010);
		apb(0, STAT_OFS, 32'h0);
		chk(rd[RETRY_BIT], 1'b1);
		chk(digitalTxOutput, 1'b0);
		bus.strobe(3'b100);
		repeat (4) @(negedge sys_clk);
		for (int i = 7; i >= 0; i--) begin
			chk(digitalTxOutput, d[i]);
			repeat (8) @(negedge sys_clk);
		end
		waitDrv(1'b0);
		@(posedge sys_clk);
		apb(0, CTRL_OFS, 32'h0);
		chk(rd[RSPS_BIT], 1'b0);
	endtask : tArb
	task tErr;
		apb(1, CTRL_OFS, 32'h28);
		apb(1, DATA_OFS, 32'h11);
		bus.pulseEod(1'b1);
		waitDrv(1'b1);
		@(posedge sys_clk);
		bus.strobe(3'b001);
		apb(0, CTRL_OFS, 32'h0);
		chk(rd[6:3], 4'h0);
	endtask : tErr
	task end_of_data_request;
		apb(1, DATA_OFS, 32'h3C);
		apb(1, CTRL_OFS, 32'h8);
		apb(0, STAT_OFS, 32'h0);
		chk(rd[EMPTY_BIT], 1'b0);
	endtask : end_of_data_request
	initial begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		apb(0, CTRL_OFS, 32'h0);
		chk(rd, {24'h0, CTRL_RST});
		tLoop;
		tFast;
		tLate;
		rsp(3'b100, 1'b0, 1'b0);
		rsp(3'b100, 1'b1, 1'b1);
		rsp(3'b010, 1'b0, 1'b1);
		rsp(3'b010, 1'b1, 1'b0);
		rsp(3'b111, 1'b0, 1'b0);
		rsp(3'b011, 1'b0, 1'b1);
		tArb;
		tErr;
		end_of_data_request;
		test_done;
	end
endmodule : tb_vpwtx_link

// [bench/vpwtx_bus_model.sv]
`timescale 1ns/1ps
module vpwtx_bus_model (
	input wire logic sys_clk,
	input wire logic digitalTxOutput,
	input wire logic txDriveEn,
	output logic busRxIn,
	output logic eodSeen,
	output logic crcOk,
	output logic busError,
	output logic arbLost,
	output logic byteSeen
);
	logic jam = 1'b0;
	initial begin
		eodSeen = 1'b0;
		crcOk = 1'b1;
		busError = 1'b0;
		arbLost = 1'b0;
		byteSeen = 1'b0;
	end
	assign busRxIn = jam | (txDriveEn & digitalTxOutput);
	task pulseEod(input logic ok);
		eodSeen <= 1'b1;
		crcOk <= ok;
		@(posedge sys_clk);
		eodSeen <= 1'b0;
	endtask : pulseEod
	task strobe(input logic [2:0] sel);
		{byteSeen, arbLost, busError} <= sel;
		@(posedge sys_clk);
		{byteSeen, arbLost, busError} <= 3'b000;
	endtask : strobe
endmodule : vpwtx_bus_model

// [bench/vpwtx_link_sva.sv]
`timescale 1ns/1ps
module vpwtx_link_sva import vpwtx_pkg::*; (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busRxIn,
	input wire logic digitalTxOutput,
	input wire logic txDriveEn,
	input wire logic digitalRxInput,
	input wire logic fastMode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic loopR;
	logic loopNxt;
	logic ctrlWr;
	assign ctrlWr = psel && penable && pwrite && paddr == CTRL_OFS;
	always_comb begin
		loopNxt = ctrlWr ? pwdata[LOOP_BIT] : loopR;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) loopR <= 1'b0;
		else loopR <= loopNxt;
	end
	AST_READY: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	AST_SLVERR: assert property (psel && penable |-> !pslverr)
		else $error("slave error raised");
	AST_RX1: assert property (
		loopR |-> digitalRxInput == digitalTxOutput)
		else $error("loopback receive not fed by transmit");
	AST_RX0: assert property (
		!loopR |-> digitalRxInput == busRxIn)
		else $error("receive not fed by bus");
	AST_FAST: assert property (
		fastMode |-> !txDriveEn)
		else $error("bus driven in receive-only mode");
	AST_FASTW: assert property (
		ctrlWr |=> fastMode == $past(pwdata[FAST_BIT]))
		else $error("fast mode does not follow write");
	AST_RST: assert property (
		$rose(arst_n) |-> !fastMode && !txDriveEn)
		else $error("outputs active after reset");
	AST_HI: assert property (psel && penable |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
endmodule : vpwtx_link_sva
bind vpwtx_link vpwtx_link_sva chk (.*);

// [verilog/vpwtx_link.sv]
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - loopback one: transmit feeds receive
// - loopback zero: receive from bus, drive
// - fast bit: receive-only at four times speed
// - format bit chooses normalization symbol value
// - end-of-data appends CRC after current byte, except in a single or multi-plain response
// - pending shadow byte sent before CRC
// - end-of-data clears holding-empty flag
// - main message: clear at first CRC bit
// - response: clear on echoed end-of-data
// - single over multi-CRC over multi-plain
// - response bits read back as written
// - responder sends normalization bit first, its value set by format bit and response type
// - one normalization bit, responders synchronise
// - multi-response arbitration loser keeps sending its byte; main message stops
// - single request: symbol then byte, no CRC
// - single request clears on done, eod, error
// - request written in the same cycle as end-of-data ignored
// - lost single byte retried without symbol
// - single byte loss sends no extra ones
// - multi-CRC request: first byte of response
// - multi-CRC: symbol then response bytes
module vpwtx_link #(
	parameter int BIT_CYC_NORM = vpwtx_pkg::BIT_CYC_NORMAL,
	parameter int BIT_CYC_4X = vpwtx_pkg::BIT_CYC_FAST
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [vpwtx_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic busRxIn,
	input wire logic eodSeen,
	input wire logic crcOk,
	input wire logic busError,
	input wire logic arbLost,
	input wire logic byteSeen,
	output logic digitalTxOutput,
	output logic txDriveEn,
	output logic digitalRxInput,
	output logic fastMode
);
	import vpwtx_pkg::*;

	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] dataReg_r, dataReg_nxt;
	logic holdFull_r, holdFull_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] crc_r, crc_nxt;
	logic [3:0] bitCnt_r, bitCnt_nxt;
	logic [15:0] tick_r, tick_nxt;
	logic crcMode_r, crcMode_nxt;
	logic inResp_r, inResp_nxt;
	logic retry_r, retry_nxt;
	logic eodArmed_r, eodArmed_nxt;
	logic txBit_r, txBit_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	vpwtx_state_e state_r, state_nxt;

	logic wrEn, rdEn, bitEnd;
	logic ctrlWr, dataWr, busy;
	logic reqS, reqM1, reqM0;
	logic [15:0] bitLen;
	logic [7:0] crcFin;

	function automatic logic [7:0] crcStep(input logic [7:0] c,
			input logic b);
		logic fb;
		fb = c[7] ^ b;
		crcStep = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
	endfunction : crcStep

	function automatic logic normValue(input logic fmt, input logic crc);
		normValue = fmt ? ~crc : crc;
	endfunction : normValue

	// raw {single, crc, plain} to one active request
	function automatic logic [2:0] prioEncode(input logic [2:0] raw);
		logic [2:0] act;
		act = 3'b000;
		if (raw[2])
			act = 3'b100;
		else if (raw[1])
			act = 3'b010;
		else if (raw[0])
			act = 3'b001;
		prioEncode = act;
	endfunction : prioEncode

	// empty flag hidden while end-of-data set
	function automatic logic [31:0] statusWord(input logic rtry,
			input logic full, input logic bsy, input logic eod);
		logic [31:0] w;
		w = 32'h00000000;
		w[RETRY_BIT] = rtry;
		w[SHADOW_BIT] = full;
		w[BUSY_BIT] = bsy;
		w[EMPTY_BIT] = ~full & ~eod;
		statusWord = w;
	endfunction : statusWord

	assign wrEn = psel & penable & pwrite;
	assign rdEn = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = prdata_r;
	assign ctrlWr = wrEn && paddr == CTRL_OFS;
	assign dataWr = wrEn && paddr == DATA_OFS;
	assign busy = state_r != VTX_IDLE;
	assign crcFin = ~crcStep(crc_r, shift_r[7]);

	assign {reqS, reqM1, reqM0} = prioEncode({ctrl_r[RSPS_BIT],
		ctrl_r[RSP1_BIT], ctrl_r[RSP0_BIT]});

	assign bitLen = ctrl_r[FAST_BIT] ? BIT_CYC_4X[15:0] : BIT_CYC_NORM[15:0];
	assign bitEnd = (tick_r == bitLen - 16'h0001);
	assign fastMode = ctrl_r[FAST_BIT];

	assign digitalRxInput = ctrl_r[LOOP_BIT] ? txBit_r : busRxIn;
	assign digitalTxOutput = txBit_r;
	assign txDriveEn = busy & ~ctrl_r[LOOP_BIT] &
		~ctrl_r[FAST_BIT];

	always_comb begin
		ctrl_nxt = ctrl_r;
		dataReg_nxt = dataReg_r;
		holdFull_nxt = holdFull_r;
		prdata_nxt = 32'h00000000;
		if (rdEn) begin
			case (paddr)
				CTRL_OFS: prdata_nxt = {24'h000000, ctrl_r};
				DATA_OFS: prdata_nxt = {24'h000000, dataReg_r};
				STAT_OFS: prdata_nxt = statusWord(retry_r, holdFull_r, busy,
					ctrl_r[EOD_BIT]);
				default: prdata_nxt = 32'h00000000;
			endcase
		end

		if (ctrlWr) begin
			ctrl_nxt = pwdata[7:0];
			if (eodSeen) begin
				ctrl_nxt[RSPS_BIT] = ctrl_r[RSPS_BIT];
				ctrl_nxt[RSP1_BIT] = ctrl_r[RSP1_BIT];
				ctrl_nxt[RSP0_BIT] = ctrl_r[RSP0_BIT];
			end
		end

		if (dataWr) begin
			dataReg_nxt = pwdata[7:0];
			holdFull_nxt = 1'b1;
		end

		if (ctrl_nxt[EOD_BIT])
			ctrl_nxt[RSPS_BIT] = 1'b0;
		if (busError) begin
			ctrl_nxt[EOD_BIT] = 1'b0;
			ctrl_nxt[RSPS_BIT] = 1'b0;
			ctrl_nxt[RSP1_BIT] = 1'b0;
			ctrl_nxt[RSP0_BIT] = 1'b0;
		end

		shift_nxt = shift_r;
		crc_nxt = crc_r;
		bitCnt_nxt = bitCnt_r;
		tick_nxt = tick_r;
		crcMode_nxt = crcMode_r;
		inResp_nxt = inResp_r;
		retry_nxt = retry_r;
		eodArmed_nxt = eodArmed_r;
		txBit_nxt = txBit_r;
		state_nxt = state_r;
		if (state_r != VTX_IDLE && state_r != VTX_WAIT)
			tick_nxt = bitEnd ? 16'h0000 : tick_r + 16'h0001;

		case (state_r)
			VTX_IDLE: begin
				tick_nxt = 16'h0000;
				txBit_nxt = 1'b0;
				retry_nxt = 1'b0;
				if (eodSeen && crcOk && (reqS | reqM1 | reqM0) &&
						!ctrl_r[FAST_BIT]) begin
					crcMode_nxt = reqM1;
					inResp_nxt = 1'b1;
					state_nxt = VTX_NORM;
					txBit_nxt = normValue(ctrl_r[NORM_BIT_FORMAT_SEL_BIT], reqM1);
				// held byte waits behind a pending response
				end else if (holdFull_r && !(reqS | reqM1 | reqM0) &&
						!ctrl_r[FAST_BIT]) begin
					crcMode_nxt = 1'b1;
					inResp_nxt = 1'b0;
					crc_nxt = CRC_INIT;
					shift_nxt = dataReg_r;
					holdFull_nxt = wrEn && paddr == DATA_OFS;
					bitCnt_nxt = 4'h0;
					state_nxt = VTX_DATA;
					txBit_nxt = dataReg_r[7];
				end
			end

			VTX_NORM: begin
				if (bitEnd) begin
					crc_nxt = CRC_INIT;
					shift_nxt = dataReg_r;
					holdFull_nxt = wrEn && paddr == DATA_OFS;
					bitCnt_nxt = 4'h0;
					state_nxt = VTX_DATA;
					txBit_nxt = dataReg_r[7];
				end
			end

			VTX_DATA: begin
				if (arbLost) begin
					if (inResp_r && reqS) begin
						retry_nxt = 1'b1;
						state_nxt = VTX_WAIT;
						txBit_nxt = 1'b0;
					end else if (inResp_r) begin
						retry_nxt = 1'b1;
					end else begin
						state_nxt = VTX_IDLE;
					end
				end
				if (arbLost && inResp_r && reqS) begin
					tick_nxt = 16'h0000;
				end else if (bitEnd) begin
					if (crcMode_r)
						crc_nxt = crcStep(crc_r, shift_r[7]);
					shift_nxt = {shift_r[6:0], 1'b0};
					bitCnt_nxt = bitCnt_r + 4'h1;
					txBit_nxt = shift_r[6];
					if (bitCnt_r == 4'h7) begin
						bitCnt_nxt = 4'h0;
						if (inResp_r && reqS) begin
							ctrl_nxt[RSPS_BIT] = 1'b0;
							state_nxt = VTX_EOD;
							txBit_nxt = 1'b0;
						end else if (holdFull_r) begin
							shift_nxt = dataReg_r;
							holdFull_nxt = wrEn && paddr == DATA_OFS;
							txBit_nxt = dataReg_r[7];
						end else if (ctrl_r[EOD_BIT] && crcMode_r) begin
							shift_nxt = crcFin;
							txBit_nxt = crcFin[7];
							state_nxt = VTX_CRC;
						end else begin
							state_nxt = VTX_EOD;
							txBit_nxt = 1'b0;
						end
					end
				end
			end

			VTX_WAIT: begin
				if (byteSeen) begin
					shift_nxt = dataReg_r;
					bitCnt_nxt = 4'h0;
					state_nxt = VTX_DATA;
					txBit_nxt = dataReg_r[7];
				end
				if (!reqS)
					state_nxt = VTX_IDLE;
			end

			VTX_CRC: begin
				if (!inResp_r && bitCnt_r == 4'h0 && tick_r == 16'h0000)
					ctrl_nxt[EOD_BIT] = 1'b0;
				if (bitEnd) begin
					shift_nxt = {shift_r[6:0], 1'b0};
					txBit_nxt = shift_r[6];
					bitCnt_nxt = bitCnt_r + 4'h1;
					if (bitCnt_r == 4'h7) begin
						state_nxt = VTX_EOD;
						txBit_nxt = 1'b0;
					end
				end
			end

			VTX_EOD: begin
				txBit_nxt = 1'b0;
				if (inResp_r)
					eodArmed_nxt = 1'b1;
				state_nxt = VTX_IDLE;
				if (inResp_r) begin
					ctrl_nxt[RSP1_BIT] = 1'b0;
					ctrl_nxt[RSP0_BIT] = 1'b0;
				end
			end

			default: state_nxt = VTX_IDLE;
		endcase

		if (eodArmed_r && eodSeen) begin
			ctrl_nxt[EOD_BIT] = 1'b0;
			eodArmed_nxt = 1'b0;
		end

		if (busError) begin
			state_nxt = VTX_IDLE;
			eodArmed_nxt = 1'b0;
		end
	end

	// reset to zero
	// register file
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= CTRL_RST;
			dataReg_r <= 8'h00;
			holdFull_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			ctrl_r <= ctrl_nxt;
			dataReg_r <= dataReg_nxt;
			holdFull_r <= holdFull_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// transmitter
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_r <= 8'h00;
			crc_r <= 8'h00;
			bitCnt_r <= 4'h0;
			tick_r <= 16'h0000;
			crcMode_r <= 1'b0;
			inResp_r <= 1'b0;
			retry_r <= 1'b0;
			eodArmed_r <= 1'b0;
			txBit_r <= 1'b0;
			state_r <= VTX_IDLE;
		end else begin
			shift_r <= shift_nxt;
			crc_r <= crc_nxt;
			bitCnt_r <= bitCnt_nxt;
			tick_r <= tick_nxt;
			crcMode_r <= crcMode_nxt;
			inResp_r <= inResp_nxt;
			retry_r <= retry_nxt;
			eodArmed_r <= eodArmed_nxt;
			txBit_r <= txBit_nxt;
			state_r <= state_nxt;
		end
	end
endmodule : vpwtx_link

// [verilog/vpwtx_pkg.sv]
package vpwtx_pkg;
	localparam int ADDR_W = 12;
	// register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] DATA_OFS = 12'h004;
	localparam logic [11:0] STAT_OFS = 12'h008;
	// control field positions
	localparam int LOOP_BIT = 0;
	localparam int FAST_BIT = 1;
	localparam int NORM_BIT_FORMAT_SEL_BIT = 2;
	localparam int EOD_BIT = 3;
	localparam int RSP0_BIT = 4;
	localparam int RSP1_BIT = 5;
	localparam int RSPS_BIT = 6;
	// status field positions
	localparam int EMPTY_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int SHADOW_BIT = 2;
	localparam int RETRY_BIT = 3;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// bit times
	localparam int CLK_MHZ = 200;
	localparam int BIT_US_NORMAL = 64;
	localparam int BIT_US_FAST = 16;
	localparam int BIT_CYC_NORMAL = BIT_US_NORMAL * CLK_MHZ;
	localparam int BIT_CYC_FAST = BIT_US_FAST * CLK_MHZ;
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	typedef enum logic [5:0] {
		VTX_IDLE = 6'b000001,
		VTX_NORM = 6'b000010,
		VTX_DATA = 6'b000100,
		VTX_CRC = 6'b001000,
		VTX_WAIT = 6'b010000,
		VTX_EOD = 6'b100000
	} vpwtx_state_e;
endpackage : vpwtx_pkg
